// [core/rts_pkg.sv]
// Package for the reset timeout and reset-cause status block
package rts_pkg;

	// ----------------------------------------
	// Clock and timing
	// ----------------------------------------
	localparam longint unsigned CLK_PERIOD_NS = 40;
	localparam longint unsigned POWER_UP_DELAY_TIMER_TIME_US = 72000;
	localparam longint unsigned POWER_UP_DELAY_TIMER_CYCLES = (POWER_UP_DELAY_TIMER_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Start-up counter counts oscillator periods; this clock is that oscillator
	localparam longint unsigned OST_TOSC = 1024;
	localparam longint unsigned OST_CYCLES = OST_TOSC;
	localparam int CNT_W = 21;

	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] OFS_STATUS = 12'h000;
	localparam logic [11:0] OFS_CONFIG = 12'h004;
	localparam logic [11:0] OFS_IRQ_STAT = 12'h008;
	localparam logic [11:0] OFS_IRQ_MASK = 12'h00c;
	localparam logic [11:0] OFS_SEQ = 12'h010;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int ST_BROWNOUT_BIT = 0;
	localparam int ST_POWERON_BIT = 1;
	localparam int ST_PARITY_BIT = 2;
	localparam int ST_PAR_EN_BIT = 7;

	localparam int IRQ_POWERON_BIT = 0;
	localparam int IRQ_BROWNOUT_BIT = 1;
	localparam int IRQ_PARITY_BIT = 2;
	localparam int IRQ_RUN_BIT = 3;
	localparam int IRQ_W = 4;

	localparam int SEQ_CORE_RST_BIT = 0;
	localparam int SEQ_POWER_UP_DELAY_TIMER_BUSY_BIT = 1;
	localparam int SEQ_OST_BUSY_BIT = 2;
	localparam int SEQ_MASTER_CLEAR_PIN_BIT = 3;

	// ----------------------------------------
	// Types and reset values
	// ----------------------------------------
	typedef struct packed {
		logic parity_check_enable;
		logic brownout_detect_enable;
		logic power_up_timer_enable;
		logic osc_is_rc;
	} rts_cfg_type;

	typedef struct packed {
		logic parity_error_flag;
		logic power_on_flag;
		logic brownout_flag;
	} rts_status_type;

	localparam rts_cfg_type CFG_RESET = '{1'b1, 1'b1, 1'b1, 1'b0};
	localparam rts_status_type STATUS_RESET = '{1'b1, 1'b0, 1'b0};
	localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 4'h0;

	typedef enum logic [2:0] {
		SEQ_POWER_LOW,
		SEQ_POWER_UP_DELAY_TIMER,
		SEQ_OST,
		SEQ_PARITY_RST,
		SEQ_RUN
	} rts_seq_type;

endpackage

// [core/rts_delay_counter.sv]
// Loadable down counter used for the power-up and start-up delays
`timescale 1ns/1ps
module rts_delay_counter #(
	parameter int WIDTH = 21
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// Control
	input wire logic start_i,
	input wire logic [WIDTH-1:0] count_i,
	// Status
	output logic busy_o,
	output logic done_o
);

	logic [WIDTH-1:0] cnt_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cnt_r <= '0;
		end else if (start_i) begin
			cnt_r <= count_i;
		end else if (cnt_r != '0) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end

	assign busy_o = (cnt_r != '0);
	// Last count; a load in the same cycle restarts and masks it
	assign done_o = (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1}) && !start_i;

endmodule

// [core/rts_reset_seq.sv]
// Reset sequencer with power-up delays, reset-cause status and APB registers
//
// Summary of operation
// - Power-up timer starts after power-on detect ends; start-up counter follows it.
// - Delay depends on oscillator type and timer enable; RC without timer has none.
// - Delays run from power-on regardless of clear pin; release then runs at once.
// - Bit 0 brown-out flag cleared by brown-out reset, set by software.
// - Brown-out flag is don't-care when brown-out detection is disabled.
// - Bit 1 power-on flag cleared on power-on reset only; software sets it.
// - Bit 2 parity flag cleared on parity reset, set on power-on, else software.
// - Bit 7 reads the parity enable, reset only by the bus reset, untouched by core resets or interrupts.
// - Fetched word parity checked; mismatch causes reset and clears parity flag.
`timescale 1ns/1ps
module rts_reset_seq
	import rts_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_TIMER_CNT = int'(POWER_UP_DELAY_TIMER_CYCLES)
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// APB slave
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	// Detectors and pin (asynchronous)
	input wire logic power_on_detect_i,
	input wire logic brownout_detect_i,
	input wire logic master_clear_pin_n_i,
	// Program fetch for parity checking
	input wire logic fetch_valid_i,
	input wire logic [13:0] fetch_word_i,
	input wire logic [1:0] fetch_parity_i,
	// Core side
	output logic core_rst_n_o,
	output logic irq_o
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [1:0] por_sync_r;
	logic [1:0] bo_sync_r;
	logic [1:0] master_clear_pin_sync_r;
	logic por_s;
	logic bo_s;
	logic master_clear_pin_n_s;
	logic por_d_r;
	logic bo_d_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			por_sync_r <= 2'h3;
			bo_sync_r <= 2'h0;
			master_clear_pin_sync_r <= 2'h0;
		end else begin
			por_sync_r <= {por_sync_r[0], power_on_detect_i};
			bo_sync_r <= {bo_sync_r[0], brownout_detect_i};
			master_clear_pin_sync_r <= {master_clear_pin_sync_r[0], master_clear_pin_n_i};
		end
	end

	assign por_s = por_sync_r[1];
	assign bo_s = bo_sync_r[1];
	assign master_clear_pin_n_s = master_clear_pin_sync_r[1];

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			por_d_r <= 1'b0;
			bo_d_r <= 1'b0;
		end else begin
			por_d_r <= por_s;
			bo_d_r <= bo_s;
		end
	end

	// ----------------------------------------
	// Configuration and events
	// ----------------------------------------
	rts_cfg_type cfg_r;
	rts_status_type status_r;
	rts_seq_type state_r;
	rts_seq_type state_nxt;
	logic core_rst_n_r;
	logic bo_active;
	logic power_low;
	logic ev_poweron;
	logic ev_brownout;
	logic ev_parity;
	logic ev_run;
	logic parity_bad;

	// Brown-out only counts when its detector is enabled
	assign bo_active = bo_s && cfg_r.brownout_detect_enable;
	assign power_low = por_s || bo_active;
	assign ev_poweron = por_s && !por_d_r;
	assign ev_brownout = bo_active && !bo_d_r && !por_s;

	// Even bits against one parity bit, odd bits against the inverted other
	assign parity_bad = (^{fetch_word_i[12], fetch_word_i[10], fetch_word_i[8], fetch_word_i[6],
		fetch_word_i[4], fetch_word_i[2], fetch_word_i[0], fetch_parity_i[0]})
		| (^{fetch_word_i[13], fetch_word_i[11], fetch_word_i[9], fetch_word_i[7],
		fetch_word_i[5], fetch_word_i[3], fetch_word_i[1], ~fetch_parity_i[1]});

	// Only fetches of a running core are checked
	assign ev_parity = fetch_valid_i && parity_bad && cfg_r.parity_check_enable
		&& core_rst_n_r && (state_r == SEQ_RUN) && !power_low;

	assign ev_run = (state_r != SEQ_RUN) && (state_nxt == SEQ_RUN);

	// ----------------------------------------
	// Delay counters
	// ----------------------------------------
	logic power_up_delay_timer_start;
	logic ost_start;
	logic power_up_delay_timer_busy;
	logic power_up_delay_timer_done;
	logic ost_busy;
	logic ost_done;

	rts_delay_counter #(
		.WIDTH(CNT_W)
	) u_power_up_delay_timer (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.start_i(power_up_delay_timer_start),
		.count_i(CNT_W'(POWER_UP_DELAY_TIMER_CNT)),
		.busy_o(power_up_delay_timer_busy),
		.done_o(power_up_delay_timer_done)
	);

	rts_delay_counter #(
		.WIDTH(CNT_W)
	) u_ost (
		.clk_sys_i(clk_sys_i),
		.rst_n_i(rst_n_i),
		.start_i(ost_start),
		.count_i(CNT_W'(OST_CYCLES)),
		.busy_o(ost_busy),
		.done_o(ost_done)
	);

	// ----------------------------------------
	// Sequence state machine
	// ----------------------------------------
	always_comb begin
		state_nxt = state_r;
		power_up_delay_timer_start = 1'b0;
		ost_start = 1'b0;
		if (power_low) begin
			state_nxt = SEQ_POWER_LOW;
		end else begin
			unique case (state_r)
				SEQ_POWER_LOW: begin
					// Timer waits for the detect pulse to end
					if (cfg_r.power_up_timer_enable) begin
						state_nxt = SEQ_POWER_UP_DELAY_TIMER;
						power_up_delay_timer_start = 1'b1;
					end else if (!cfg_r.osc_is_rc) begin
						state_nxt = SEQ_OST;
						ost_start = 1'b1;
					end else begin
						state_nxt = SEQ_RUN;
					end
				end
				SEQ_POWER_UP_DELAY_TIMER: begin
					if (power_up_delay_timer_done) begin
						if (cfg_r.osc_is_rc) begin
							state_nxt = SEQ_RUN;
						end else begin
							state_nxt = SEQ_OST;
							ost_start = 1'b1;
						end
					end
				end
				SEQ_OST: begin
					if (ost_done) begin
						state_nxt = SEQ_RUN;
					end
				end
				SEQ_PARITY_RST: begin
					state_nxt = SEQ_RUN;
				end
				SEQ_RUN: begin
					if (ev_parity) begin
						state_nxt = SEQ_PARITY_RST;
					end
				end
				default: begin
					state_nxt = SEQ_POWER_LOW;
				end
			endcase
		end
	end

	// Pin level plays no part in the timing
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			state_r <= SEQ_POWER_LOW;
		end else begin
			state_r <= state_nxt;
		end
	end

	// Held while pin low or a delay runs; release follows the pin at once
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			core_rst_n_r <= 1'b0;
		end else begin
			core_rst_n_r <= master_clear_pin_n_s && (state_nxt == SEQ_RUN) && !power_low;
		end
	end

	assign core_rst_n_o = core_rst_n_r;

	// ----------------------------------------
	// APB access decode
	// ----------------------------------------
	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic acc_first;
	logic wr_done;
	logic addr_ok;
	logic [31:0] rd_mux;
	logic [IRQ_W-1:0] irq_stat_r;
	logic [IRQ_W-1:0] irq_mask_r;
	logic irq_r;

	// One wait state: data is built on the first access cycle
	assign acc_first = psel_i && penable_i && !pready_r;
	assign wr_done = psel_i && penable_i && pready_r && pwrite_i && !pslverr_r;
	assign addr_ok = (paddr_i == OFS_STATUS) || (paddr_i == OFS_CONFIG) || (paddr_i == OFS_IRQ_STAT)
		|| (paddr_i == OFS_IRQ_MASK) || (paddr_i == OFS_SEQ);

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (paddr_i)
			OFS_STATUS: begin
				rd_mux[ST_BROWNOUT_BIT] = status_r.brownout_flag;
				rd_mux[ST_POWERON_BIT] = status_r.power_on_flag;
				rd_mux[ST_PARITY_BIT] = status_r.parity_error_flag;
				rd_mux[ST_PAR_EN_BIT] = cfg_r.parity_check_enable;
			end
			OFS_CONFIG: begin
				rd_mux[3:0] = cfg_r;
			end
			OFS_IRQ_STAT: begin
				rd_mux[IRQ_W-1:0] = irq_stat_r;
			end
			OFS_IRQ_MASK: begin
				rd_mux[IRQ_W-1:0] = irq_mask_r;
			end
			OFS_SEQ: begin
				rd_mux[SEQ_CORE_RST_BIT] = !core_rst_n_r;
				rd_mux[SEQ_POWER_UP_DELAY_TIMER_BUSY_BIT] = power_up_delay_timer_busy;
				rd_mux[SEQ_OST_BUSY_BIT] = ost_busy;
				rd_mux[SEQ_MASTER_CLEAR_PIN_BIT] = master_clear_pin_n_s;
			end
			default: begin
				rd_mux = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			pready_r <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r <= 32'h0000_0000;
		end else begin
			pready_r <= acc_first;
			pslverr_r <= acc_first && !addr_ok;
			if (acc_first && !pwrite_i) begin
				prdata_r <= rd_mux;
			end else if (!acc_first) begin
				prdata_r <= 32'h0000_0000;
			end
		end
	end

	assign pready_o = pready_r;
	assign pslverr_o = pslverr_r;
	assign prdata_o = prdata_r;

	// ----------------------------------------
	// Configuration register
	// ----------------------------------------
	// Only the bus reset touches it; core resets and interrupts never do
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cfg_r <= CFG_RESET;
		end else if (wr_done && (paddr_i == OFS_CONFIG)) begin
			cfg_r <= pwdata_i[3:0];
		end
	end

	// ----------------------------------------
	// Reset-cause status register
	// ----------------------------------------
	logic st_wr;

	assign st_wr = wr_done && (paddr_i == OFS_STATUS);

	// Hardware causes win over a software write in the same cycle
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			status_r.brownout_flag <= STATUS_RESET.brownout_flag;
		end else if (ev_brownout) begin
			status_r.brownout_flag <= 1'b0;
		end else if (st_wr) begin
			status_r.brownout_flag <= pwdata_i[ST_BROWNOUT_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			status_r.power_on_flag <= STATUS_RESET.power_on_flag;
		end else if (ev_poweron) begin
			status_r.power_on_flag <= 1'b0;
		end else if (st_wr) begin
			status_r.power_on_flag <= pwdata_i[ST_POWERON_BIT];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			status_r.parity_error_flag <= STATUS_RESET.parity_error_flag;
		end else if (ev_poweron) begin
			status_r.parity_error_flag <= 1'b1;
		end else if (ev_parity) begin
			status_r.parity_error_flag <= 1'b0;
		end else if (st_wr) begin
			status_r.parity_error_flag <= pwdata_i[ST_PARITY_BIT];
		end
	end

	// ----------------------------------------
	// Interrupt status, mask and output
	// ----------------------------------------
	logic [IRQ_W-1:0] irq_set;
	logic [IRQ_W-1:0] irq_clr;

	assign irq_set = {ev_run, ev_parity, ev_brownout, ev_poweron};
	assign irq_clr = (wr_done && (paddr_i == OFS_IRQ_STAT)) ? pwdata_i[IRQ_W-1:0] : '0;

	// Write one to clear; a new event in that cycle stays set
	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_stat_r <= '0;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | irq_set;
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_mask_r <= IRQ_MASK_RESET;
		end else if (wr_done && (paddr_i == OFS_IRQ_MASK)) begin
			irq_mask_r <= pwdata_i[IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			irq_r <= 1'b0;
		end else begin
			irq_r <= |(irq_stat_r & irq_mask_r);
		end
	end

	assign irq_o = irq_r;

endmodule

// [tb/rts_reset_seq_properties.sv]
// Port-level checks of the reset sequencer
`timescale 1ns/1ps
module rts_reset_seq_properties
	import rts_pkg::*;
#(
	parameter int unsigned POWER_UP_DELAY_TIMER_CNT = 20
) (
	// Clock and reset
	input wire logic clk_sys_i,
	input wire logic rst_n_i,
	// APB
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [11:0] paddr_i,
	input wire logic [31:0] pwdata_i,
	input wire logic [31:0] prdata_o,
	input wire logic pready_o,
	input wire logic pslverr_o,
	// Detectors, pin, fetch, core
	input wire logic power_on_detect_i,
	input wire logic brownout_detect_i,
	input wire logic master_clear_pin_n_i,
	input wire logic fetch_valid_i,
	input wire logic [13:0] fetch_word_i,
	input wire logic [1:0] fetch_parity_i,
	input wire logic core_rst_n_o,
	input wire logic irq_o
);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	logic unmapped;
	logic bad_par;
	assign unmapped = !(paddr_i inside {OFS_STATUS, OFS_CONFIG, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_SEQ});
	// Odd parity bit is stored inverted
	assign bad_par = (^(fetch_word_i & 14'h1555) ^ fetch_parity_i[0]) | (^(fetch_word_i & 14'h2aaa) ^ ~fetch_parity_i[1]);

	// Shadow of the configuration word; only completed, accepted writes move it
	rts_cfg_type cfg_seen_r;

	always_ff @(posedge clk_sys_i) begin
		if (!rst_n_i) begin
			cfg_seen_r <= CFG_RESET;
		end else if (psel_i && penable_i && pready_o && pwrite_i && !pslverr_o && (paddr_i == OFS_CONFIG)) begin
			cfg_seen_r <= pwdata_i[3:0];
		end
	end

	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	apb_wait_state_a: assert property (psel_i && penable_i && !pready_o |=> pready_o) else $error("ready late");
	ready_pulse_a: assert property (pready_o |=> !pready_o) else $error("ready stuck");
	ready_in_access_a: assert property (pready_o |-> psel_i && penable_i) else $error("stray ready");
	read_data_idle_a: assert property (!(pready_o && !pwrite_i) |-> prdata_o == 32'h0) else $error("read data leak");
	unmapped_err_a: assert property (pready_o |-> pslverr_o == unmapped) else $error("error flag wrong");
	pin_holds_core_a: assert property (!master_clear_pin_n_i [*4] |-> !core_rst_n_o) else $error("pin ignored");
	power_on_holds_a: assert property (power_on_detect_i [*4] |-> !core_rst_n_o) else $error("run in power-on");
	parity_reset_a: assert property (fetch_valid_i && core_rst_n_o && bad_par && cfg_seen_r.parity_check_enable
		|-> ##[1:2] !core_rst_n_o) else $error("parity miss");
	brownout_holds_a: assert property ((brownout_detect_i && cfg_seen_r.brownout_detect_enable) [*4] |-> !core_rst_n_o)
		else $error("run in brown-out");
	reset_quiet_a: assert property ($rose(rst_n_i) |-> !core_rst_n_o && !irq_o && !pready_o) else $error("reset out");
endmodule

bind rts_reset_seq rts_reset_seq_properties #(.POWER_UP_DELAY_TIMER_CNT(POWER_UP_DELAY_TIMER_CNT)) u_props (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
	.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .power_on_detect_i(power_on_detect_i),
	.brownout_detect_i(brownout_detect_i), .master_clear_pin_n_i(master_clear_pin_n_i),
	.fetch_valid_i(fetch_valid_i), .fetch_word_i(fetch_word_i), .fetch_parity_i(fetch_parity_i),
	.core_rst_n_o(core_rst_n_o), .irq_o(irq_o));

// [tb/rts_board_model.sv]
// Board model: switch to ground on the clear pin, with pull-up
`timescale 1ns/1ps
module rts_board_model (
	// Clock
	input wire logic clk_sys_i,
	// Bench command
	input wire logic hold_low_i,
	// Pin
	output logic master_clear_pin_n_o = 1'b1
);
	// ----------------------------------------
	// Switch
	// ----------------------------------------
	// Released pin floats to the pull-up level
	always @(posedge clk_sys_i) begin
		master_clear_pin_n_o <= !hold_low_i;
	end
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the reset sequencer
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin tests_run++; if ((got) !== (ex)) begin error_cnt++; \
	$display("unexpected %s: expected %0h seen %0h", nm, ex, got); end end
module tb_top
	import rts_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	localparam int POWER_UP_DELAY_TIMER = 20;
	typedef struct {logic [31:0] cfg; int dly;} rts_row_type;
	rts_row_type rows [4] = '{'{32'he, POWER_UP_DELAY_TIMER + 1024}, '{32'hf, POWER_UP_DELAY_TIMER}, '{32'hc, 1024}, '{32'hd, 0}};
	logic clk_sys_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pod = 1'b0, bo = 1'b0, hold = 1'b0, fv = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, pin_n, core_rst_n, irq;
	logic [13:0] fw = 14'h0;
	logic [1:0] fp = 2'b10;
	int error_cnt = 0;
	int tests_run = 0;
	int d;

	initial begin
		forever #20 clk_sys_i = ~clk_sys_i;
	end

	rts_board_model board (.clk_sys_i(clk_sys_i), .hold_low_i(hold), .master_clear_pin_n_o(pin_n));
	rts_reset_seq #(.POWER_UP_DELAY_TIMER_CNT(POWER_UP_DELAY_TIMER)) dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel),
		.penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
		.pready_o(pready), .pslverr_o(pslverr), .power_on_detect_i(pod), .brownout_detect_i(bo),
		.master_clear_pin_n_i(pin_n), .fetch_valid_i(fv), .fetch_word_i(fw), .fetch_parity_i(fp),
		.core_rst_n_o(core_rst_n), .irq_o(irq));

	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
		@(posedge clk_sys_i);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		@(posedge clk_sys_i);
		penable <= 1'b1;
		do @(posedge clk_sys_i); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Counts cycles from detector release (or pin release) to core run
	task automatic pulse(input logic brown, input int hold_cyc, output int n);
		hold <= (hold_cyc > 0);
		bo <= brown;
		pod <= !brown;
		repeat (6) @(posedge clk_sys_i);
		bo <= 1'b0;
		pod <= 1'b0;
		repeat (hold_cyc) @(posedge clk_sys_i);
		if (hold_cyc > 0) `CHK("core held", 1'b0, core_rst_n)
		hold <= 1'b0;
		n = 0;
		while (core_rst_n !== 1'b1) begin
			@(posedge clk_sys_i);
			n++;
		end
	endtask

	task automatic fetch(input logic [13:0] w, input logic [1:0] p);
		@(posedge clk_sys_i);
		fv <= 1'b1;
		fw <= w;
		fp <= p;
		@(posedge clk_sys_i);
		fv <= 1'b0;
		repeat (4) @(posedge clk_sys_i);
	endtask

	task automatic tally_and_finish;
		$display("checks %0d, mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk_sys_i);
		error_cnt++;
		tally_and_finish;
	end

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, OFS_CONFIG, rows[i].cfg);
			apb(1'b1, OFS_STATUS, 32'h3);
			pulse(1'b0, 0, d);
			`CHK("delay window", 1'b1, d >= rows[i].dly && d <= rows[i].dly + 8)
			apb(1'b0, OFS_STATUS, 32'h0);
			`CHK("status after power-on", 32'h85, rd)
		end
		$display("test delay table ended");
		apb(1'b1, OFS_CONFIG, 32'he);
		pulse(1'b0, 1200, d);
		`CHK("release lag", 1'b1, d <= 6)
		apb(1'b1, OFS_STATUS, 32'h0);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("read-only mirror", 32'h80, rd)
		apb(1'b0, 12'h014, 32'h0);
		`CHK("unmapped error", 1'b1, err)
		$display("test pin and registers ended");
		apb(1'b1, OFS_STATUS, 32'h7);
		apb(1'b1, OFS_IRQ_STAT, 32'hf);
		pulse(1'b1, 0, d);
		`CHK("brown-out delay", 1'b1, d >= POWER_UP_DELAY_TIMER + 1024 && d <= POWER_UP_DELAY_TIMER + 1032)
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status after brown-out", 32'h86, rd)
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		`CHK("brown-out event", 1'b1, rd[IRQ_BROWNOUT_BIT])
		`CHK("masked irq", 1'b0, irq)
		apb(1'b1, OFS_IRQ_MASK, 32'h2);
		repeat (2) @(posedge clk_sys_i);
		`CHK("unmasked irq", 1'b1, irq)
		apb(1'b1, OFS_IRQ_STAT, 32'hf);
		repeat (2) @(posedge clk_sys_i);
		`CHK("cleared irq", 1'b0, irq)
		apb(1'b1, OFS_CONFIG, 32'h2);
		pulse(1'b1, 0, d);
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		`CHK("brown-out ignored", 1'b0, rd[IRQ_BROWNOUT_BIT])
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("mirror follows enable", 32'h06, rd)
		$display("test brown-out ended");
		apb(1'b1, OFS_CONFIG, 32'he);
		apb(1'b1, OFS_STATUS, 32'h7);
		fetch(14'h3fff, 2'b01);
		`CHK("good word runs", 1'b1, core_rst_n)
		fetch(14'h0000, 2'b00);
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status after parity", 32'h83, rd)
		$display("test parity ended");
		// Mid-run reset: registers back to reset values, delays run again
		apb(1'b1, OFS_CONFIG, 32'h1);
		rst_n_i <= 1'b0;
		repeat (2) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		@(posedge clk_sys_i);
		`CHK("core after reset", 1'b0, core_rst_n)
		`CHK("irq after reset", 1'b0, irq)
		apb(1'b0, OFS_CONFIG, 32'h0);
		`CHK("config after reset", 32'he, rd)
		apb(1'b0, OFS_STATUS, 32'h0);
		`CHK("status after reset", 32'h84, rd)
		apb(1'b0, OFS_SEQ, 32'h0);
		`CHK("sequence while timing", 32'hb, rd)
		while (core_rst_n !== 1'b1) @(posedge clk_sys_i);
		apb(1'b0, OFS_SEQ, 32'h0);
		`CHK("sequence when running", 32'h8, rd)
		apb(1'b0, OFS_IRQ_STAT, 32'h0);
		`CHK("events after reset", 32'h9, rd)
		`CHK("mask cleared by reset", 1'b0, irq)
		$display("test reset ended");
		tally_and_finish;
	end
endmodule
